// File: rtl/pid_filter_defs.vh
// Constants shared by the filter parameter loader design and testbench files
`ifndef PID_FILTER_DEFS_VH
`define PID_FILTER_DEFS_VH

// Command codes
`define LOAD_FILTER_CMD      8'h1E
`define APPLY_FILTER_CMD     8'h04
`define LOAD_TRAJECTORY_CMD  8'h1F

// Filter control word fields
`define FCW_INTERVAL_MSB     15
`define FCW_INTERVAL_LSB     8
`define FCW_SEL_PROP         3
`define FCW_SEL_INTEG        2
`define FCW_SEL_DERIV        1
`define FCW_SEL_LIMIT        0

// Trajectory control word load bits (each item is two words)
`define TCW_SEL_ACCEL        5
`define TCW_SEL_VEL          3
`define TCW_SEL_POS          1
`define TRAJ_BYTES_PER_ITEM  4'h4

// Interval step length in device clocks
`define CLKS_PER_STEP        2048
`define STEP_CNT_W           11
`define STEP_CNT_LAST        11'h7FF

// APB byte addresses
`define ADDR_CMD             12'h000
`define ADDR_DATA            12'h004
`define ADDR_STATUS          12'h008
`define ADDR_PROP_GAIN       12'h00C
`define ADDR_INTEG_GAIN      12'h010
`define ADDR_DERIV_GAIN      12'h014
`define ADDR_INTEG_LIMIT     12'h018

// Status register bits
`define STAT_BUSY            0
`define STAT_APPLY_PENDING   1
`define STAT_LOADING         2

// Reset values
`define RST_GAIN             16'h0000
`define RST_INTERVAL         8'h00

`endif

// File: rtl/integral_clamp.v
// Integral term clamp against the working integration limit
`timescale 1ns/1ps
module integral_clamp
(
   input  wire               clk,
   input  wire               reset,
   input  wire signed [31:0] integral_in,
   input  wire        [15:0] limit,
   output reg  signed [31:0] integral_out
);
   wire signed [31:0] pos_lim;
   wire signed [31:0] neg_lim;

   assign pos_lim = {16'h0000, limit};
   assign neg_lim = -pos_lim;

   always @(posedge clk)
   begin
      if (reset)
         integral_out <= 32'h00000000;
      else if (integral_in > pos_lim)
         integral_out <= pos_lim; // R12
      else if (integral_in < neg_lim)
         integral_out <= neg_lim; // R12
      else
         integral_out <= integral_in;
   end
endmodule // integral_clamp

// File: rtl/pid_filter_param_loader.v
// Filter parameter loader: command decode, double buffers, update, clamp
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pid_filter_defs.vh"

// Overview of operation
// R1: Command 1E starts a filter load of two to ten bytes, allowed in motion.
// R2: First two data bytes form the control word, high byte first.
// R3: Control word bits 15..8 are the derivative interval code, bit 8 lsb.
// R4: Derivative interval is (code+1) times 2048 device clocks.
// R5: Control word bits 7..4 are ignored.
// R6: Bits 3..0 select proportional, integral, derivative gain and limit.
// R7: A control word with no select bits ends the command at once.
// R8: Selected words follow high byte first, in fixed order P, I, D, limit.
// R9: Host waits for busy clear before each byte pair.
// R10: Host keeps and resends the interval field; it is not readable.
// R11: Host sends gains and limit only within 0000..7FFF.
// R12: Integral term magnitude above the limit is replaced by signed limit.
// R13: Loaded values go to holding buffers only until the update command.
// R14: Command 04 copies all buffered parameters, interval too, to working.
// R15: The copy happens at a computation boundary, never mid-calculation.
// R16: Command 1F accepts two to fourteen data bytes.
// R17: Host keeps trajectory values within their documented ranges.
// R18: Two bytes per selected bit are expected; the last byte ends the load.
// R19: An update with nothing newly loaded leaves working values unchanged.
module pid_filter_param_loader
(
   input  wire        REF_CLK,
   input  wire        RESET,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire [31:0] INTEGRAL_TERM,
   output wire [31:0] CLAMPED_INTEGRAL,
   output reg  [15:0] PROPORTIONAL_GAIN,
   output reg  [15:0] INTEGRAL_GAIN,
   output reg  [15:0] DERIVATIVE_GAIN,
   output reg  [15:0] INTEGRATION_LIMIT,
   output reg  [7:0]  DERIV_INTERVAL,
   output reg         CALC_TICK,
   output reg         DERIV_TICK
);
   localparam [2:0] ST_IDLE   = 3'd0;
   localparam [2:0] ST_FCW_HI = 3'd1;
   localparam [2:0] ST_FCW_LO = 3'd2;
   localparam [2:0] ST_COEF   = 3'd3;
   localparam [2:0] ST_TCW_HI = 3'd4;
   localparam [2:0] ST_TCW_LO = 3'd5;
   localparam [2:0] ST_TDATA  = 3'd6;

   reg  [2:0]  state;
   reg  [7:0]  hi_byte;
   reg         hi_seen;
   reg  [3:0]  sel_left;
   reg  [3:0]  traj_left;
   reg  [15:0] buf_prop;
   reg  [15:0] buf_integ;
   reg  [15:0] buf_deriv;
   reg  [15:0] buf_limit;
   reg  [7:0]  buf_interval;
   reg         dirty;
   reg         apply_pending;
   reg  [`STEP_CNT_W-1:0] step_cnt;
   reg  [7:0]  interval_cnt;

   wire        acc_phase;
   wire        wr_cmd;
   wire        wr_data;
   wire [7:0]  data_byte;
   wire [15:0] data_word;
   wire        step_end;
   wire        busy;

   // Highest remaining select bit: fixed P, I, D, limit order
   function [3:0] next_sel;
      input [3:0] sel;
      begin
         if (sel[`FCW_SEL_PROP])
            next_sel = 4'b1000;
         else if (sel[`FCW_SEL_INTEG])
            next_sel = 4'b0100;
         else if (sel[`FCW_SEL_DERIV])
            next_sel = 4'b0010;
         else if (sel[`FCW_SEL_LIMIT])
            next_sel = 4'b0001;
         else
            next_sel = 4'b0000;
      end
   endfunction

   function addr_mapped;
      input [11:0] a;
      begin
         addr_mapped = (a == `ADDR_CMD) || (a == `ADDR_DATA) ||
                       (a == `ADDR_STATUS) || (a == `ADDR_PROP_GAIN) ||
                       (a == `ADDR_INTEG_GAIN) || (a == `ADDR_DERIV_GAIN) ||
                       (a == `ADDR_INTEG_LIMIT);
      end
   endfunction

   assign acc_phase = PSEL & PENABLE & PREADY;
   assign wr_cmd    = acc_phase & PWRITE & (PADDR == `ADDR_CMD);
   assign wr_data   = acc_phase & PWRITE & (PADDR == `ADDR_DATA);
   assign data_byte = PWDATA[7:0];
   assign data_word = {hi_byte, data_byte};
   assign step_end  = (step_cnt == `STEP_CNT_LAST);
   // Busy while a coefficient byte pair is half written or an update waits
   assign busy      = hi_seen | apply_pending;

   // APB answer: one wait state, so PREADY rises in the access phase
   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end
      else if (PSEL & PENABLE & ~PREADY)
      begin
         PREADY  <= 1'b1;
         PSLVERR <= ~addr_mapped(PADDR);
         PRDATA  <= 32'h00000000;
         if (~PWRITE)
         begin
            case (PADDR)
               `ADDR_STATUS:
                  PRDATA <= {29'h00000000, (state != ST_IDLE),
                             apply_pending, busy};
               `ADDR_PROP_GAIN:
                  PRDATA <= {16'h0000, PROPORTIONAL_GAIN};
               `ADDR_INTEG_GAIN:
                  PRDATA <= {16'h0000, INTEGRAL_GAIN};
               `ADDR_DERIV_GAIN:
                  PRDATA <= {16'h0000, DERIVATIVE_GAIN};
               `ADDR_INTEG_LIMIT:
                  PRDATA <= {16'h0000, INTEGRATION_LIMIT};
               default:
                  PRDATA <= 32'h00000000;
            endcase
         end
      end
      else
      begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // Command and data byte sequencer; a new command aborts an old one
   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         state        <= ST_IDLE;
         hi_byte      <= 8'h00;
         hi_seen      <= 1'b0;
         sel_left     <= 4'h0;
         traj_left    <= 4'h0;
         buf_prop     <= `RST_GAIN;
         buf_integ    <= `RST_GAIN;
         buf_deriv    <= `RST_GAIN;
         buf_limit    <= `RST_GAIN;
         buf_interval <= `RST_INTERVAL;
         dirty        <= 1'b0;
      end
      else if (wr_cmd)
      begin
         hi_seen <= 1'b0;
         case (data_byte)
            `LOAD_FILTER_CMD:
               state <= ST_FCW_HI; // R1
            `LOAD_TRAJECTORY_CMD:
               state <= ST_TCW_HI; // R16
            default:
               state <= ST_IDLE;
         endcase
      end
      else if (wr_data)
      begin
         case (state)
            ST_FCW_HI:
            begin
               hi_byte <= data_byte; // R2
               state   <= ST_FCW_LO;
            end
            ST_FCW_LO:
            begin
               buf_interval <= hi_byte; // R3 R13
               dirty        <= 1'b1;
               sel_left     <= data_byte[3:0]; // R5 R6
               if (data_byte[3:0] == 4'h0)
                  state <= ST_IDLE; // R7
               else
                  state <= ST_COEF;
            end
            ST_COEF:
            begin
               if (~hi_seen)
               begin
                  hi_byte <= data_byte; // R8
                  hi_seen <= 1'b1;
               end
               else
               begin
                  hi_seen <= 1'b0;
                  // A word landing after an update must still be copied later
                  dirty   <= 1'b1; // R14
                  case (next_sel(sel_left)) // R8
                     4'b1000: buf_prop  <= data_word; // R13
                     4'b0100: buf_integ <= data_word;
                     4'b0010: buf_deriv <= data_word;
                     4'b0001: buf_limit <= data_word;
                     default: buf_limit <= buf_limit;
                  endcase
                  sel_left <= sel_left & ~next_sel(sel_left);
                  if ((sel_left & ~next_sel(sel_left)) == 4'h0)
                     state <= ST_IDLE; // R18
               end
            end
            ST_TCW_HI:
            begin
               hi_byte <= data_byte;
               state   <= ST_TCW_LO;
            end
            ST_TCW_LO:
            begin
               // Trajectory items are counted and discarded here
               traj_left <= (hi_byte[0] ? 4'h0 : 4'h0) +
                  (data_byte[`TCW_SEL_ACCEL] ? `TRAJ_BYTES_PER_ITEM : 4'h0) +
                  (data_byte[`TCW_SEL_VEL]   ? `TRAJ_BYTES_PER_ITEM : 4'h0) +
                  (data_byte[`TCW_SEL_POS]   ? `TRAJ_BYTES_PER_ITEM : 4'h0);
               if (data_byte[`TCW_SEL_ACCEL] | data_byte[`TCW_SEL_VEL] |
                   data_byte[`TCW_SEL_POS])
                  state <= ST_TDATA;
               else
                  state <= ST_IDLE; // R16
            end
            ST_TDATA:
            begin
               traj_left <= traj_left - 4'h1;
               if (traj_left == 4'h1)
                  state <= ST_IDLE; // R16
            end
            default:
               state <= ST_IDLE;
         endcase
      end
      else if (apply_pending && step_end)
         dirty <= 1'b0;
   end

   // Update request is held until the next computation boundary
   always @(posedge REF_CLK)
   begin
      if (RESET)
         apply_pending <= 1'b0;
      else if (wr_cmd && (data_byte == `APPLY_FILTER_CMD))
         apply_pending <= 1'b1; // R14
      else if (step_end)
         apply_pending <= 1'b0; // R15
   end

   // Working registers change only at a step boundary
   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         PROPORTIONAL_GAIN <= `RST_GAIN;
         INTEGRAL_GAIN     <= `RST_GAIN;
         DERIVATIVE_GAIN   <= `RST_GAIN;
         INTEGRATION_LIMIT <= `RST_GAIN;
         DERIV_INTERVAL    <= `RST_INTERVAL;
      end
      else if (apply_pending && step_end && dirty) // R15 R19
      begin
         PROPORTIONAL_GAIN <= buf_prop; // R14
         INTEGRAL_GAIN     <= buf_integ;
         DERIVATIVE_GAIN   <= buf_deriv;
         INTEGRATION_LIMIT <= buf_limit;
         DERIV_INTERVAL    <= buf_interval;
      end
   end

   // Step divider and derivative interval counter
   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         step_cnt     <= {`STEP_CNT_W{1'b0}};
         interval_cnt <= 8'h00;
         CALC_TICK    <= 1'b0;
         DERIV_TICK   <= 1'b0;
      end
      else
      begin
         step_cnt   <= step_cnt + 1'b1; // R4
         CALC_TICK  <= step_end;
         DERIV_TICK <= 1'b0;
         if (step_end)
         begin
            if (interval_cnt >= DERIV_INTERVAL)
            begin
               interval_cnt <= 8'h00;
               DERIV_TICK   <= 1'b1; // R4
            end
            else
               interval_cnt <= interval_cnt + 8'h01;
         end
      end
   end

   integral_clamp u_clamp
   (
      .clk          (REF_CLK),
      .reset        (RESET),
      .integral_in  (INTEGRAL_TERM),
      .limit        (INTEGRATION_LIMIT),
      .integral_out (CLAMPED_INTEGRAL)
   );
endmodule // pid_filter_param_loader

// File: sim/pid_filter_chk.sv
// Port-level assertions for the filter parameter loader
`timescale 1ns/1ps
module pid_filter_chk
(
   input wire        REF_CLK,
   input wire        RESET,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   input wire [31:0] INTEGRAL_TERM,
   input wire [31:0] CLAMPED_INTEGRAL,
   input wire [15:0] PROPORTIONAL_GAIN,
   input wire [15:0] INTEGRAL_GAIN,
   input wire [15:0] DERIVATIVE_GAIN,
   input wire [15:0] INTEGRATION_LIMIT,
   input wire [7:0]  DERIV_INTERVAL,
   input wire        CALC_TICK,
   input wire        DERIV_TICK
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   wire signed [31:0] it  = INTEGRAL_TERM;
   wire signed [31:0] lim = {16'h0000, INTEGRATION_LIMIT};
   reg         [11:0] cnt;
   reg                seen;
   // The first step after reset is longer, so only later steps are timed
   always @(posedge REF_CLK)
      cnt <= (RESET | CALC_TICK) ? 12'h000 : cnt + 12'h001;
   always @(posedge REF_CLK)
      seen <= !RESET && (seen || CALC_TICK);
   AST_CLAMP_HI: assert property
      (it > lim |=> CLAMPED_INTEGRAL == $past(lim))
      else $error("clamp above limit wrong");
   AST_CLAMP_LO: assert property
      (it < -lim |=> CLAMPED_INTEGRAL == -$past(lim))
      else $error("clamp below limit wrong");
   AST_CLAMP_PASS: assert property
      (it <= lim && it >= -lim |=> CLAMPED_INTEGRAL == $past(it))
      else $error("integral term not passed");
   AST_WORK_AT_TICK: assert property
      (!$stable({PROPORTIONAL_GAIN, INTEGRAL_GAIN, DERIVATIVE_GAIN,
         INTEGRATION_LIMIT, DERIV_INTERVAL}) |-> ##[0:1] CALC_TICK)
      else $error("working values changed off a boundary");
   AST_STEP_LEN: assert property
      (CALC_TICK && seen |-> cnt == 12'h7FF)
      else $error("step is not 2048 clocks");
   AST_DERIV_ON_STEP: assert property
      (DERIV_TICK |-> CALC_TICK)
      else $error("derivative sample off a step");
   AST_ONE_WAIT: assert property
      (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("transfer not answered after one wait");
   AST_ERR_RDY: assert property
      (PSLVERR |-> PREADY)
      else $error("error without ready");
endmodule // pid_filter_chk

bind pid_filter_param_loader pid_filter_chk chk
(
   .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .INTEGRAL_TERM(INTEGRAL_TERM),
   .CLAMPED_INTEGRAL(CLAMPED_INTEGRAL),
   .PROPORTIONAL_GAIN(PROPORTIONAL_GAIN), .INTEGRAL_GAIN(INTEGRAL_GAIN),
   .DERIVATIVE_GAIN(DERIVATIVE_GAIN), .INTEGRATION_LIMIT(INTEGRATION_LIMIT),
   .DERIV_INTERVAL(DERIV_INTERVAL), .CALC_TICK(CALC_TICK),
   .DERIV_TICK(DERIV_TICK)
);

// File: sim/apb_host.sv
// Host model: APB master issuing loader commands
`timescale 1ns/1ps
`include "pid_filter_defs.vh"
module apb_host
(
   input  wire        clk,
   input  wire        pready,
   input  wire        pslverr,
   input  wire [31:0] prdata,
   output reg         psel = 1'b0,
   output reg         penable = 1'b0,
   output reg         pwrite = 1'b0,
   output reg  [11:0] paddr = 12'h000,
   output reg  [31:0] pwdata = 32'h00000000
);
   reg        err;
   reg [31:0] rd;
   task xfer(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle bus shows the inverse so stale values cannot pass
      paddr   <= ~a;
      pwdata  <= ~d;
   end
   endtask
   task word(input [15:0] v);
   begin
      rd = 32'h00000001;
      while (rd[`STAT_BUSY] !== 1'b0)
         xfer(1'b0, `ADDR_STATUS, 32'h00000000);
      xfer(1'b1, `ADDR_DATA, {24'h000000, v[15:8]});
      xfer(1'b1, `ADDR_DATA, {24'h000000, v[7:0]});
   end
   endtask
   // Caller resends the interval code in every control word
   task load(input [15:0] cw, input [15:0] p, i, dg, l);
   begin
      xfer(1'b1, `ADDR_CMD, {24'h000000, `LOAD_FILTER_CMD});
      word(cw);
      if (cw[`FCW_SEL_PROP])  word(p);
      if (cw[`FCW_SEL_INTEG]) word(i);
      if (cw[`FCW_SEL_DERIV]) word(dg);
      if (cw[`FCW_SEL_LIMIT]) word(l);
   end
   endtask
   task traj;
      integer k;
   begin
      xfer(1'b1, `ADDR_CMD, {24'h000000, `LOAD_TRAJECTORY_CMD});
      word(16'h002A);
      for (k = 0; k < 6; k = k + 1)
         word(16'h0000);
   end
   endtask
endmodule // apb_host

// File: sim/tb_pid_filter_param_loader.sv
// Self-checking bench for the filter parameter loader
`timescale 1ns/1ps
`include "pid_filter_defs.vh"
module tb_pid_filter_param_loader;
   reg         clk;
   reg         rst;
   reg  [31:0] iterm;
   wire        psel, penable, pwrite, pready, pslverr, ctick, dtick;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata, clamped;
   wire [15:0] prop, integ, deriv, lim;
   wire [7:0]  ivl;
   integer     n_mismatch = 0;
   integer     cmp_count = 0;
   integer     n;
   pid_filter_param_loader dut (.REF_CLK(clk), .RESET(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .INTEGRAL_TERM(iterm), .CLAMPED_INTEGRAL(clamped),
      .PROPORTIONAL_GAIN(prop), .INTEGRAL_GAIN(integ),
      .DERIVATIVE_GAIN(deriv), .INTEGRATION_LIMIT(lim),
      .DERIV_INTERVAL(ivl), .CALC_TICK(ctick), .DERIV_TICK(dtick));
   apb_host host (.clk(clk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   task check(input [31:0] seen, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task gains(input [15:0] p, i, d, l, input [7:0] v);
   begin
      check({prop, integ}, {p, i});
      check({deriv, lim}, {d, l});
      check({24'h000000, ivl}, {24'h000000, v});
   end
   endtask
   // Two boundaries, since the command may land just before one
   task apply;
      integer j;
   begin
      host.xfer(1'b1, `ADDR_CMD, {24'h000000, `APPLY_FILTER_CMD});
      for (j = 0; j < 2; j = j + 1)
      begin
         n = 0;
         @(posedge clk);
         while (ctick !== 1'b1 && n < 2100)
         begin
            @(posedge clk);
            n = n + 1;
         end
         check({31'h00000000, ctick}, 32'h00000001);
      end
   end
   endtask
   task gap;
   begin
      n = 1;
      @(posedge clk);
      while (dtick !== 1'b1 && n < 7000)
      begin
         @(posedge clk);
         n = n + 1;
      end
      check({31'h00000000, dtick}, 32'h00000001);
   end
   endtask
   task clamp(input [31:0] v, input [31:0] e);
   begin
      @(posedge clk);
      iterm <= v;
      repeat (2) @(posedge clk);
      check(clamped, e);
   end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      n_mismatch = n_mismatch + 1;
      conclude;
   end
   initial
   begin
      rst = 1'b1;
      iterm = 32'h00000000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      gains(16'h0000, 16'h0000, 16'h0000, 16'h0000, 8'h00);
      host.xfer(1'b0, 12'hFFC, 32'h00000000);
      check({31'h00000000, host.err}, 32'h00000001);
      $display("reset test done");
      host.load(16'h03FF, 16'h1234, 16'h0567, 16'h7FFF, 16'h0100);
      repeat (3000) @(posedge clk);
      gains(16'h0000, 16'h0000, 16'h0000, 16'h0000, 8'h00);
      apply;
      gains(16'h1234, 16'h0567, 16'h7FFF, 16'h0100, 8'h03);
      host.xfer(1'b0, `ADDR_PROP_GAIN, 32'h00000000);
      check(host.rd, 32'h00001234);
      $display("full load test done");
      host.load(16'h0305, 16'h0000, 16'h2222, 16'h0000, 16'h0200);
      host.word(16'h5555);
      apply;
      gains(16'h1234, 16'h2222, 16'h7FFF, 16'h0200, 8'h03);
      $display("partial load test done");
      host.load(16'h0200, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      host.xfer(1'b0, `ADDR_STATUS, 32'h00000000);
      check(host.rd & 32'h00000004, 32'h00000000);
      apply;
      gains(16'h1234, 16'h2222, 16'h7FFF, 16'h0200, 8'h02);
      gap;
      gap;
      check(n, 32'h00001800);
      apply;
      gains(16'h1234, 16'h2222, 16'h7FFF, 16'h0200, 8'h02);
      $display("interval test done");
      host.traj;
      host.xfer(1'b0, `ADDR_STATUS, 32'h00000000);
      check(host.rd & 32'h00000004, 32'h00000000);
      host.load(16'h0308, 16'h0ABC, 16'h0000, 16'h0000, 16'h0000);
      apply;
      gains(16'h0ABC, 16'h2222, 16'h7FFF, 16'h0200, 8'h03);
      $display("trajectory test done");
      clamp(32'h00001000, 32'h00000200);
      clamp(32'hFFFFF000, 32'hFFFFFE00);
      clamp(32'h00000200, 32'h00000200);
      clamp(32'hFFFFFE00, 32'hFFFFFE00);
      clamp(32'h00000123, 32'h00000123);
      $display("clamp test done");
      conclude;
   end
endmodule // tb_pid_filter_param_loader
